// [vdcfg_pkg.sv]
// Constants shared by the voice detector configuration slice.
// Assumes an 8-bit register port fed by the control bus front end.
package vdcfg_pkg;
  localparam logic [7:0] VDCFG_OFS_PAGE_SELECT = 8'h00;
  localparam logic [7:0] VDCFG_OFS_CONFIG_ONE = 8'h1E;
  localparam logic [7:0] VDCFG_OFS_CONFIG_TWO = 8'h1F;
  localparam logic [7:0] VDCFG_DETECT_PAGE = 8'h01;
  localparam logic [7:0] VDCFG_RST_PAGE_SELECT = 8'h00;
  localparam logic [7:0] VDCFG_RST_CONFIG_ONE = 8'h20;
  localparam logic [7:0] VDCFG_RST_CONFIG_TWO = 8'h08;
  localparam int VDCFG_POS_POLICY = 6;
  localparam int VDCFG_POS_CHANNEL = 4;
  localparam int VDCFG_POS_CLOCK_SOURCE_CONFIG = 2;
  localparam int VDCFG_POS_CLK_RATE = 0;
  localparam int VDCFG_POS_RSVD_HI = 7;
  localparam int VDCFG_POS_IRQ_EN = 6;
  localparam int VDCFG_POS_RSVD_MID = 4;
  localparam int VDCFG_POS_DET_REC = 3;
  // Writable bits of the second register; bits 5 and 2-0 are read-only zero.
  localparam logic [7:0] VDCFG_TWO_WR_MASK = 8'hD8;
  localparam logic [7:0] VDCFG_READ_UNMAPPED = 8'h00;
  typedef enum logic [1:0] {
    VDCFG_POLICY_HOST = 2'h0,
    VDCFG_POLICY_AUTO = 2'h1,
    VDCFG_POLICY_AUTO_UP = 2'h2,
    VDCFG_POLICY_AUTO_DOWN = 2'h3
  } vdcfg_policy_t;
  typedef enum logic [1:0] {
    VDCFG_CLK_OSC = 2'h0,
    VDCFG_CLK_BITCLK = 2'h1,
    VDCFG_CLK_MASTER = 2'h2,
    VDCFG_CLK_CUSTOM = 2'h3
  } vdcfg_clock_source_config_t;
  // External detector clock rate in kHz per rate code.
  localparam int VDCFG_EXT_KHZ_0 = 3072;
  localparam int VDCFG_EXT_KHZ_1 = 6144;
  localparam int VDCFG_EXT_KHZ_2 = 12288;
  localparam int VDCFG_EXT_KHZ_3 = 18432;
endpackage

// [vdcfg_power_policy.sv]
// ADC power state keeper that follows the selected power policy.
// Assumes host commands and detector events are one-cycle pulses on CLK.
`timescale 1ns/1ns
`default_nettype none
module vdcfg_power_policy
  import vdcfg_pkg::*;
(
  input wire logic clk, // Device clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic clk_en, // Freezes state while low.
  input wire logic [1:0] policy, // Power policy field.
  input wire logic host_up, // Host power-up command pulse.
  input wire logic host_down, // Host power-down command pulse.
  input wire logic irq_up, // Detector event asking for power-up.
  input wire logic irq_down, // Detector event asking for power-down.
  output logic adc_on // ADC powered state.
);
  typedef enum logic {VDCFG_ADC_OFF, VDCFG_ADC_ON} vdcfg_adc_t;
  vdcfg_adc_t state;
  logic up_ok;
  logic down_ok;

  always_comb begin
    up_ok = 1'b0;
    down_ok = 1'b0;
    case (vdcfg_policy_t'(policy))
      VDCFG_POLICY_HOST: begin
        up_ok = host_up;
        down_ok = host_down;
      end
      VDCFG_POLICY_AUTO: begin
        up_ok = irq_up;
        down_ok = irq_down;
      end
      VDCFG_POLICY_AUTO_UP: begin
        up_ok = irq_up;
        down_ok = host_down;
      end
      VDCFG_POLICY_AUTO_DOWN: begin
        up_ok = host_up;
        down_ok = irq_down;
      end
      default: begin
        up_ok = 1'b0;
        down_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= VDCFG_ADC_OFF;
    end else if (clk_en) begin
      case (state)
        VDCFG_ADC_OFF: begin
          if (up_ok) begin
            state <= VDCFG_ADC_ON;
          end
        end
        VDCFG_ADC_ON: begin
          if (down_ok) begin
            state <= VDCFG_ADC_OFF;
          end
        end
        default: begin
          state <= VDCFG_ADC_OFF;
        end
      endcase
    end
  end

  assign adc_on = (state == VDCFG_ADC_ON);
endmodule
`default_nettype wire

// [vdcfg_regs.sv]
// Page select and voice detector configuration registers with their effects.
// Assumes a control bus front end on CLK that drives one-cycle read and
// write strobes with an 8-bit offset; all inputs are synchronous to CLK.
//
// Functional notes
// - Page select at offset zero, resets zero.
// - Every page value 0 to 255 selects itself.
// - Policy 0: host alone powers ADC.
// - Policy 1: detector events power ADC up/down.
// - Policy 2: detector up, host down.
// - Policy 3: host up, detector down.
// - Channel field picks channel n+1, reset three.
// - Clock source: oscillator, bit clock, master clock.
// - Clock source 3 follows page-0 clock settings.
// - Rate code gives external clock frequency.
// - Interrupt enable turns data pin into interrupt while ADC is off.
// - Detect-while-recording bit keeps detector running.
// - First register at 0x1E, resets 0x20.
// - Second register at 0x1F, resets 0x08.
// - Detector runs only while enable bit set.
`timescale 1ns/1ns
`default_nettype none
module vdcfg_regs
  import vdcfg_pkg::*;
(
  input wire logic CLK, // Device clock, 10 MHz.
  input wire logic SYS_RST, // Asynchronous reset, active high.
  input wire logic CLK_EN, // Clock enable; state frozen while low.
  input wire logic REG_WR, // Register write strobe.
  input wire logic REG_RD, // Register read strobe.
  input wire logic [7:0] REG_ADDR, // Register offset within page.
  input wire logic [7:0] REG_WDATA, // Write data.
  output logic [7:0] REG_RDATA, // Read data, valid after read strobe.
  input wire logic DETECTOR_ENABLE, // Detector enable bit from page 0.
  input wire logic HOST_ADC_UP, // Host ADC power-up command pulse.
  input wire logic HOST_ADC_DOWN, // Host ADC power-down command pulse.
  input wire logic VOICE_IRQ_UP, // Detector voice-found event pulse.
  input wire logic VOICE_IRQ_DOWN, // Detector silence event pulse.
  input wire logic VOICE_IRQ_LEVEL, // Detector interrupt level.
  input wire logic AUDIO_SDATA, // Audio serial port data bit.
  input wire logic [1:0] CUSTOM_CLK_SEL, // Source from page-0 clock settings.
  output logic [7:0] PAGE, // Currently selected page.
  output logic ADC_POWER_ON, // ADC power state.
  output logic DETECTOR_RUN, // Detector algorithm running.
  output logic [1:0] MONITORED_CHANNEL_PICK, // Monitored channel minus one.
  output logic [3:0] CHANNEL_ONEHOT, // Monitored channel, one-hot.
  output logic [1:0] DETECTOR_CLOCK_SOURCE, // Effective detector clock source.
  output logic [1:0] DETECTOR_EXT_CLOCK_RATE, // External clock rate code.
  output logic [15:0] DETECTOR_EXT_CLOCK_KHZ, // External clock rate in kHz.
  output logic SERIAL_OUT_IRQ_MODE, // Data pin carries interrupt.
  output logic SERIAL_DATA_OUT_PIN // Serial data output pin.
);
  logic [7:0] page_select;
  logic [7:0] voice_detect_config_one;
  logic [7:0] voice_detect_config_two;
  logic on_detect_page;
  logic adc_on;
  logic irq_en;
  logic det_rec;
  logic next_run;
  logic next_irq_mode;

  function automatic logic [15:0] rate_khz(input logic [1:0] code);
    case (code)
      2'h0: rate_khz = 16'(VDCFG_EXT_KHZ_0);
      2'h1: rate_khz = 16'(VDCFG_EXT_KHZ_1);
      2'h2: rate_khz = 16'(VDCFG_EXT_KHZ_2);
      default: rate_khz = 16'(VDCFG_EXT_KHZ_3);
    endcase
  endfunction

  assign on_detect_page = (page_select == VDCFG_DETECT_PAGE);
  assign irq_en = voice_detect_config_two[VDCFG_POS_IRQ_EN];
  assign det_rec = voice_detect_config_two[VDCFG_POS_DET_REC];

  // The page register is reached at offset zero on every page.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      page_select <= VDCFG_RST_PAGE_SELECT;
      PAGE <= VDCFG_RST_PAGE_SELECT;
    end else if (CLK_EN && REG_WR && REG_ADDR == VDCFG_OFS_PAGE_SELECT) begin
      page_select <= REG_WDATA;
      PAGE <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      voice_detect_config_one <= VDCFG_RST_CONFIG_ONE;
    end else if (CLK_EN && REG_WR && on_detect_page &&
                 REG_ADDR == VDCFG_OFS_CONFIG_ONE) begin
      voice_detect_config_one <= REG_WDATA;
    end
  end

  // Reserved bits 7 and 4 hold what the host writes, which should be zero.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      voice_detect_config_two <= VDCFG_RST_CONFIG_TWO;
    end else if (CLK_EN && REG_WR && on_detect_page &&
                 REG_ADDR == VDCFG_OFS_CONFIG_TWO) begin
      voice_detect_config_two <= REG_WDATA & VDCFG_TWO_WR_MASK;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA <= VDCFG_READ_UNMAPPED;
    end else if (CLK_EN && REG_RD) begin
      if (REG_ADDR == VDCFG_OFS_PAGE_SELECT) begin
        REG_RDATA <= page_select;
      end else if (on_detect_page && REG_ADDR == VDCFG_OFS_CONFIG_ONE) begin
        REG_RDATA <= voice_detect_config_one;
      end else if (on_detect_page && REG_ADDR == VDCFG_OFS_CONFIG_TWO) begin
        REG_RDATA <= voice_detect_config_two & VDCFG_TWO_WR_MASK;
      end else begin
        REG_RDATA <= VDCFG_READ_UNMAPPED;
      end
    end
  end

  vdcfg_power_policy u_policy (
    .clk(CLK),
    .rst(SYS_RST),
    .clk_en(CLK_EN),
    .policy(voice_detect_config_one[VDCFG_POS_POLICY +: 2]),
    .host_up(HOST_ADC_UP),
    .host_down(HOST_ADC_DOWN),
    .irq_up(VOICE_IRQ_UP),
    .irq_down(VOICE_IRQ_DOWN),
    .adc_on(adc_on)
  );

  // Detection while recording stops when the recording bit is cleared.
  always_comb begin
    next_run = DETECTOR_ENABLE && (!adc_on || det_rec);
    next_irq_mode = irq_en && !adc_on;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ADC_POWER_ON <= 1'b0;
      DETECTOR_RUN <= 1'b0;
      SERIAL_OUT_IRQ_MODE <= 1'b0;
      SERIAL_DATA_OUT_PIN <= 1'b0;
    end else if (CLK_EN) begin
      ADC_POWER_ON <= adc_on;
      DETECTOR_RUN <= next_run;
      SERIAL_OUT_IRQ_MODE <= next_irq_mode;
      SERIAL_DATA_OUT_PIN <= next_irq_mode ? VOICE_IRQ_LEVEL : AUDIO_SDATA;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      MONITORED_CHANNEL_PICK <= VDCFG_RST_CONFIG_ONE[VDCFG_POS_CHANNEL +: 2];
      CHANNEL_ONEHOT <= 4'h4;
      DETECTOR_CLOCK_SOURCE <= VDCFG_CLK_OSC;
      DETECTOR_EXT_CLOCK_RATE <= 2'h0;
      DETECTOR_EXT_CLOCK_KHZ <= 16'(VDCFG_EXT_KHZ_0);
    end else if (CLK_EN) begin
      MONITORED_CHANNEL_PICK <= voice_detect_config_one[VDCFG_POS_CHANNEL +: 2];
      CHANNEL_ONEHOT <= 4'h1 << voice_detect_config_one[VDCFG_POS_CHANNEL +: 2];
      if (voice_detect_config_one[VDCFG_POS_CLOCK_SOURCE_CONFIG +: 2] == VDCFG_CLK_CUSTOM) begin
        DETECTOR_CLOCK_SOURCE <= CUSTOM_CLK_SEL;
      end else begin
        DETECTOR_CLOCK_SOURCE <= voice_detect_config_one[VDCFG_POS_CLOCK_SOURCE_CONFIG +: 2];
      end
      DETECTOR_EXT_CLOCK_RATE <= voice_detect_config_one[VDCFG_POS_CLK_RATE +: 2];
      DETECTOR_EXT_CLOCK_KHZ <= rate_khz(voice_detect_config_one[VDCFG_POS_CLK_RATE +: 2]);
    end
  end
endmodule
`default_nettype wire

// [vdcfg_regs_props.sv]
// Port assertions for the detector configuration slice.
// Assumes it is bound into every vdcfg_regs instance.
`timescale 1ns/1ns
`default_nettype none
module vdcfg_regs_props (
  input wire logic CLK, // Clock.
  input wire logic SYS_RST, // Reset.
  input wire logic CLK_EN, // Enable.
  input wire logic REG_RD, // Read.
  input wire logic [7:0] REG_ADDR, // Offset.
  input wire logic [7:0] REG_RDATA, // Data.
  input wire logic DETECTOR_ENABLE, // Enable bit.
  input wire logic HOST_ADC_UP, // Up.
  input wire logic HOST_ADC_DOWN, // Down.
  input wire logic VOICE_IRQ_UP, // Up.
  input wire logic VOICE_IRQ_DOWN, // Down.
  input wire logic ADC_POWER_ON, // Power.
  input wire logic DETECTOR_RUN, // Run.
  input wire logic [1:0] MONITORED_CHANNEL_PICK, // Pick.
  input wire logic [3:0] CHANNEL_ONEHOT, // One-hot.
  input wire logic [1:0] DETECTOR_EXT_CLOCK_RATE, // Rate.
  input wire logic [15:0] DETECTOR_EXT_CLOCK_KHZ, // Rate in kHz.
  input wire logic SERIAL_OUT_IRQ_MODE // Irq mode.
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  wire logic taken_rd = REG_RD && CLK_EN;
  onehot_match_a: assert property (CHANNEL_ONEHOT == 4'h1 << MONITORED_CHANNEL_PICK)
    else $error("one-hot channel wrong");
  khz_map_a: assert property (DETECTOR_EXT_CLOCK_KHZ == ((DETECTOR_EXT_CLOCK_RATE == 2'h3) ?
    16'h4800 : (16'h0C00 << DETECTOR_EXT_CLOCK_RATE))) else $error("clock rate wrong");
  run_enable_a: assert property ($past(CLK_EN) && DETECTOR_RUN |-> $past(DETECTOR_ENABLE))
    else $error("detector ran while disabled");
  rdata_hold_a: assert property (!taken_rd |=> $stable(REG_RDATA))
    else $error("read data moved");
  unmapped_zero_a: assert property (taken_rd && !(REG_ADDR inside {8'h00, 8'h1E, 8'h1F})
    |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
  reserved_zero_a: assert property (taken_rd && REG_ADDR == 8'h1F
    |=> (REG_RDATA & 8'h27) == 8'h00) else $error("reserved bits not zero");
  irq_mode_off_a: assert property (ADC_POWER_ON && $past(ADC_POWER_ON) && $past(CLK_EN)
    |-> !SERIAL_OUT_IRQ_MODE) else $error("irq mode while recording");
  power_up_cause_a: assert property ($rose(ADC_POWER_ON)
    |-> $past(HOST_ADC_UP || VOICE_IRQ_UP, 2)) else $error("power-up without cause");
  power_down_cause_a: assert property ($fell(ADC_POWER_ON)
    |-> $past(HOST_ADC_DOWN || VOICE_IRQ_DOWN, 2)) else $error("power-down without cause");
endmodule
bind vdcfg_regs vdcfg_regs_props u_props (.CLK, .SYS_RST, .CLK_EN, .REG_RD, .REG_ADDR,
  .REG_RDATA, .DETECTOR_ENABLE, .HOST_ADC_UP, .HOST_ADC_DOWN, .VOICE_IRQ_UP, .VOICE_IRQ_DOWN,
  .ADC_POWER_ON, .DETECTOR_RUN, .MONITORED_CHANNEL_PICK, .CHANNEL_ONEHOT,
  .DETECTOR_EXT_CLOCK_RATE, .DETECTOR_EXT_CLOCK_KHZ, .SERIAL_OUT_IRQ_MODE);
`default_nettype wire

// [vdcfg_host_model.sv]
// Control bus host model: one register access at a time.
// Assumes the slice takes strobes at the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module vdcfg_host_model (
  input wire logic clk, // Clock.
  output logic reg_wr, // Write strobe.
  output logic reg_rd, // Read strobe.
  output logic [7:0] reg_addr, // Offset.
  output logic [7:0] reg_wdata, // Write data.
  input wire logic [7:0] reg_rdata // Read data.
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Released data shows the inverse so a stale value is never taken.
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// [vdcfg_regs_tb_top.sv]
// Self-checking bench for the detector configuration slice.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module vdcfg_regs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic en = 1'b0;
  logic lvl = 1'b0;
  logic sd = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [1:0] csel = 2'h2;
  logic wr, rd, on, run, irqm, pin, up, ok, exp_on;
  logic [7:0] addr, wdata, rdata, got, pgo;
  logic [1:0] pick, src, rate;
  logic [3:0] oh;
  logic [15:0] khz;
  logic [7:0] pg [3] = '{8'hFF, 8'h02, 8'h01};
  int ord [4] = '{2, 0, 3, 1};
  int num_errors = 0;
  int n_compared = 0;
  always #50 clk = ~clk;
  vdcfg_host_model u_host (.clk, .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata));
  vdcfg_regs u_dut (.CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .DETECTOR_ENABLE(en),
    .HOST_ADC_UP(ev[0]), .HOST_ADC_DOWN(ev[1]), .VOICE_IRQ_UP(ev[2]), .VOICE_IRQ_DOWN(ev[3]),
    .VOICE_IRQ_LEVEL(lvl), .AUDIO_SDATA(sd), .CUSTOM_CLK_SEL(csel), .PAGE(pgo),
    .ADC_POWER_ON(on), .DETECTOR_RUN(run), .MONITORED_CHANNEL_PICK(pick),
    .CHANNEL_ONEHOT(oh), .DETECTOR_CLOCK_SOURCE(src), .DETECTOR_EXT_CLOCK_RATE(rate),
    .DETECTOR_EXT_CLOCK_KHZ(khz), .SERIAL_OUT_IRQ_MODE(irqm), .SERIAL_DATA_OUT_PIN(pin));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, got);
    chk("read data", 16'(e), 16'(got));
  endtask
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev <= 4'h1 << i;
    @(posedge clk);
    ev <= 4'h0;
    settle;
  endtask
  task automatic results;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    en <= 1'b1;
    settle;
    chk("pick", 16'h2, 16'(pick));
    chk("page", 16'h0, 16'(pgo));
    rchk(8'h00, 8'h00);
    for (int p = 0; p < 3; p++) begin
      u_host.wr(8'h00, pg[p]);
      rchk(8'h00, pg[p]);
      chk("page", 16'(pg[p]), 16'(pgo));
      rchk(8'h1E, (pg[p] == 8'h01) ? 8'h20 : 8'h00);
    end
    rchk(8'h1F, 8'h08);
    rchk(8'h20, 8'h00);
    u_host.wr(8'h1F, 8'hFF);
    rchk(8'h1F, 8'hD8);
    for (int i = 0; i < 4; i++) begin
      u_host.wr(8'h1E, {2'h0, i[1:0], i[1:0], i[1:0]});
      settle;
      chk("onehot", 16'h1 << i, 16'(oh));
      chk("source", (i == 3) ? 16'(csel) : 16'(i), 16'(src));
      chk("rate", 16'(i), 16'(rate));
      chk("khz", (i == 3) ? 16'd18432 : (16'd3072 << i), khz);
    end
    u_host.wr(8'h1F, 8'h48);
    @(posedge clk);
    lvl <= 1'b1;
    settle;
    chk("irq mode", 16'h1, 16'(irqm));
    chk("pin", 16'h1, 16'(pin));
    u_host.wr(8'h1F, 8'h08);
    settle;
    chk("pin", 16'h0, 16'(pin));
    for (int p = 0; p < 4; p++) begin
      u_host.wr(8'h1E, {p[1:0], 6'h20});
      exp_on = 1'b0;
      for (int k = 0; k < 4; k++) begin
        up = (ord[k] % 2) == 0;
        ok = (ord[k] < 2) ? (p == 0 || p == (up ? 3 : 2)) : (p == 1 || p == (up ? 2 : 3));
        exp_on = ok ? up : exp_on;
        pulse(ord[k]);
        chk("adc power", 16'(exp_on), 16'(on));
      end
    end
    u_host.wr(8'h1E, 8'h20);
    u_host.wr(8'h1F, 8'h00);
    pulse(0);
    chk("run", 16'h0, 16'(run));
    u_host.wr(8'h1F, 8'h08);
    settle;
    chk("run", 16'h1, 16'(run));
    @(posedge clk);
    en <= 1'b0;
    ce <= 1'b0;
    u_host.wr(8'h00, 8'h55);
    ce <= 1'b1;
    settle;
    chk("run", 16'h0, 16'(run));
    rchk(8'h00, 8'h01);
    chk("page", 16'h1, 16'(pgo));
    results;
  end
  // Ends a hung run; the tests need well under a thousand cycles.
  initial begin
    #1000000;
    num_errors++;
    results;
  end
endmodule
`default_nettype wire
